// ==== include/sni_params.svh ====
/*
 * Constants of the two-wire nonvolatile RAM slave: array geometry,
 * write-protect window, stream FIFO shape and synchroniser reset levels.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SNI_PARAMS_SVH
`define SNI_PARAMS_SVH

// Array geometry: 8,192 locations of 8 bits, 13 decoded address bits
`define SNI_MEM_DEPTH 8192
`define SNI_ADDR_W 13
`define SNI_DATA_W 8
`define SNI_ADDR_LAST 13'h1fff
`define SNI_ADDR_ZERO 13'h0000

// Upper quadrant guarded by the write-protect pin
`define SNI_PROT_BASE 13'h1800

// Serial byte framing
`define SNI_BITS_PER_BYTE 4'h8
`define SNI_DEV_TYPE_MSB 7
`define SNI_DEV_TYPE_LSB 4
`define SNI_SEL_MSB 3
`define SNI_SEL_LSB 1
`define SNI_RW_BIT 0
`define SNI_AHI_MSB 4

// Write stream FIFO: address and data of each committed byte
`define SNI_FIFO_DEPTH 8
`define SNI_FIFO_W 21

// Pin synchroniser: SCL, SDA, WP, three select pins; bus lines idle high
`define SNI_SYNC_W 6
`define SNI_SYNC_RST 6'h03

`endif

// ==== include/sni_pkg.sv ====
/*
 * Types of the two-wire nonvolatile RAM slave.
 * Assumes nothing of its surroundings; used as sni_pkg::name.
 */
`default_nettype none

package sni_pkg;

	// Byte-level protocol state of the slave
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_DEV,
		ST_AHI,
		ST_ALO,
		ST_WDATA,
		ST_RDATA,
		ST_MACK
	} sni_state_t;

endpackage : sni_pkg

`default_nettype wire

// ==== hdl/sni_sync.sv ====
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes asynchronous pins on i_d and a synchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module sni_sync #(
	parameter int W = 6,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);

	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;
	logic [W-1:0] next_q;

	// A bit moves only once stages two and three agree, so a metastable
	// first stage never reaches the decoder and single-cycle glitches die
	always_comb begin
		for (int i = 0; i < W; i++) begin
			next_q[i] = (s2[i] == s3[i]) ? s3[i] : o_q[i];
		end
	end

	// Stage one feeds stage two only
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			s1 <= RST;
			s2 <= RST;
			s3 <= RST;
			o_q <= RST;
		end else begin
			s1 <= i_d;
			s2 <= s1;
			s3 <= s2;
			o_q <= next_q;
		end
	end

endmodule : sni_sync

`default_nettype wire

// ==== hdl/sni_fifo.sv ====
/*
 * Synchronous valid/ready FIFO, width and depth as parameters.
 * Assumes DEPTH is a power of two and one clock for both sides.
 */
`timescale 1ns/1ps
`default_nettype none

module sni_fifo #(
	parameter int W = 21,
	parameter int DEPTH = 8
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_in_valid,
	output logic o_in_ready,
	input wire logic [W-1:0] i_in_data,
	output logic o_out_valid,
	input wire logic i_out_ready,
	output logic [W-1:0] o_out_data
);

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] cnt;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_cnt;
	logic push;
	logic pop;

	// Full and empty come straight from the fill count
	assign o_in_ready = (cnt != (AW+1)'(DEPTH));
	assign o_out_valid = (cnt != '0);
	assign o_out_data = mem[rd_ptr];
	assign push = i_in_valid & o_in_ready;
	assign pop = o_out_valid & i_out_ready;

	// Pointers wrap by overflow, hence the power-of-two depth
	always_comb begin
		next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
		next_cnt = cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			cnt <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			cnt <= next_cnt;
		end
	end

	// Storage needs no reset; the count guards what is read
	always_ff @(posedge i_clk) begin
		if (push) begin
			mem[wr_ptr] <= i_in_data;
		end
	end

endmodule : sni_fifo

`default_nettype wire

// ==== hdl/sni_slave.sv ====
/*
 * Two-wire slave front end of an 8192 x 8 nonvolatile RAM, with the array,
 * write protection and a stream of committed writes on a link clock.
 * Assumes a free-running system clock far faster than SCL, an external bus
 * master and pull-up on SDA, and a consumer on the link clock side.
 */
`timescale 1ns/1ps
`default_nettype none
`include "sni_params.svh"

module sni_slave #(
	parameter logic [3:0] P_DEV_TYPE = 4'h5 // Arbitrary device-type value
) (
	input wire logic I_CLK_SYS,
	input wire logic I_RST,
	input wire logic I_CLK_LINK,
	input wire logic I_RST_LINK,
	input wire logic I_SCL,
	input wire logic I_SDA,
	output logic O_SDA_O,
	output logic O_SDA_OE,
	input wire logic I_WP,
	input wire logic [2:0] I_DEVICE_SELECT_PINS,
	output logic O_WR_VALID,
	input wire logic I_WR_READY,
	output logic [`SNI_ADDR_W-1:0] O_WR_ADDR,
	output logic [`SNI_DATA_W-1:0] O_WR_DATA
);

	function automatic logic is_protected(input logic wp_pin, input logic [`SNI_ADDR_W-1:0] a);
		return wp_pin && (a >= `SNI_PROT_BASE);
	endfunction : is_protected

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisation and bus condition decode

	logic [`SNI_SYNC_W-1:0] pins;
	logic scl;
	logic sda;
	logic wp;
	logic [2:0] sel;
	logic scl_d;
	logic sda_d;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;
	logic evt_sda;

	// Three-stage filter absorbs slow edges; 250 MHz gives over 20 samples per SCL phase
	sni_sync #(.W(`SNI_SYNC_W), .RST(`SNI_SYNC_RST)) u_sync (
		.i_clk(I_CLK_SYS),
		.i_rst(I_RST),
		.i_d({I_DEVICE_SELECT_PINS, I_WP, I_SDA, I_SCL}), // SCL only ever enters
		.o_q(pins)
	);

	assign scl = pins[0];
	assign sda = pins[1];
	assign wp = pins[2];
	assign sel = pins[5:3];

	// Edges of the filtered lines give the four bus conditions
	assign scl_rise = scl & ~scl_d;
	assign scl_fall = ~scl & scl_d;
	assign start_cond = scl & scl_d & sda_d & ~sda;
	assign stop_cond = scl & scl_d & ~sda_d & sda;
	assign evt_sda = scl_fall | start_cond | stop_cond;

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl;
			sda_d <= sda;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Byte protocol engine and array

	sni_pkg::sni_state_t st;
	sni_pkg::sni_state_t next_st;
	logic [3:0] bitcnt;
	logic [3:0] next_bitcnt;
	logic [7:0] shreg;
	logic [7:0] next_shreg;
	logic ackph;
	logic next_ackph;
	logic mack_ok;
	logic next_mack_ok;
	logic sda_oe;
	logic next_sda_oe;
	logic [`SNI_ADDR_W-1:0] addr;
	logic [`SNI_ADDR_W-1:0] next_addr;
	logic [`SNI_DATA_W-1:0] mem [`SNI_MEM_DEPTH];
	logic [`SNI_DATA_W-1:0] rd_byte;
	logic mem_we;
	logic do_load;
	logic prot_hit;
	logic fifo_in_ready;

	assign rd_byte = mem[addr];
	assign prot_hit = is_protected(wp, addr);

	// Start and stop outrank everything, so either one aborts a byte in flight
	always_comb begin
		next_st = st;
		next_bitcnt = bitcnt;
		next_shreg = shreg;
		next_ackph = ackph;
		next_mack_ok = mack_ok;
		next_sda_oe = sda_oe;
		next_addr = addr;
		mem_we = 1'b0;
		do_load = 1'b0;
		if (start_cond) begin
			next_st = sni_pkg::ST_DEV;
			next_bitcnt = '0;
			next_ackph = 1'b0;
			next_sda_oe = 1'b0;
		end else if (stop_cond) begin
			next_st = sni_pkg::ST_IDLE;
			next_ackph = 1'b0;
			next_sda_oe = 1'b0;
		end else if (scl_rise) begin
			if (st == sni_pkg::ST_MACK) begin
				next_mack_ok = ~sda;
			end else if (!ackph && st != sni_pkg::ST_IDLE) begin
				if (st != sni_pkg::ST_RDATA) begin
					next_shreg = {shreg[6:0], sda};
				end
				next_bitcnt = bitcnt + 4'h1;
			end
		end else if (scl_fall) begin
			if (ackph) begin
				// Acknowledge slot over: release, then start a read byte if due
				next_ackph = 1'b0;
				next_sda_oe = 1'b0;
				do_load = (st == sni_pkg::ST_RDATA);
			end else if (st == sni_pkg::ST_MACK) begin
				// A missing master acknowledge ends the read
				if (mack_ok) begin
					next_st = sni_pkg::ST_RDATA;
					do_load = 1'b1;
				end else begin
					next_st = sni_pkg::ST_IDLE;
				end
			end else if (st == sni_pkg::ST_RDATA) begin
				if (bitcnt == `SNI_BITS_PER_BYTE) begin
					next_sda_oe = 1'b0;
					next_st = sni_pkg::ST_MACK;
					next_bitcnt = '0;
					next_mack_ok = 1'b0;
				end else begin
					next_sda_oe = ~shreg[7]; // Low bit pulls, high bit releases
					next_shreg = {shreg[6:0], 1'b0};
				end
			end else if (bitcnt == `SNI_BITS_PER_BYTE && st != sni_pkg::ST_IDLE) begin
				next_bitcnt = '0;
				unique case (st)
					sni_pkg::ST_DEV: begin
						// Type, select bits and read flag of the address byte
						if (shreg[`SNI_DEV_TYPE_MSB:`SNI_DEV_TYPE_LSB] == P_DEV_TYPE &&
							shreg[`SNI_SEL_MSB:`SNI_SEL_LSB] == sel) begin
							next_ackph = 1'b1;
							next_sda_oe = 1'b1;
							next_st = shreg[`SNI_RW_BIT] ? sni_pkg::ST_RDATA : sni_pkg::ST_AHI;
						end else begin
							next_st = sni_pkg::ST_IDLE;
						end
					end
					sni_pkg::ST_AHI: begin
						// Top three bits of the high byte are dropped
						next_addr[`SNI_ADDR_W-1:8] = shreg[`SNI_AHI_MSB:0];
						next_ackph = 1'b1;
						next_sda_oe = 1'b1;
						next_st = sni_pkg::ST_ALO;
					end
					sni_pkg::ST_ALO: begin
						next_addr[7:0] = shreg;
						next_ackph = 1'b1;
						next_sda_oe = 1'b1;
						next_st = sni_pkg::ST_WDATA;
					end
					sni_pkg::ST_WDATA: begin
						// A full stream FIFO is refused like a protected byte
						if (!prot_hit && fifo_in_ready) begin
							mem_we = 1'b1;
							next_addr = addr + 13'h0001;
							next_ackph = 1'b1;
							next_sda_oe = 1'b1;
						end else begin
							next_st = sni_pkg::ST_IDLE;
						end
					end
					default: begin
						next_st = sni_pkg::ST_IDLE;
					end
				endcase
			end
		end
		if (do_load) begin
			// Address moves on as the byte is fetched, wrapping by width
			next_shreg = {rd_byte[6:0], 1'b0};
			next_sda_oe = ~rd_byte[7];
			next_addr = addr + 13'h0001;
			next_bitcnt = '0;
		end
	end

	// Reset leaves the slave unselected with SDA released
	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			st <= sni_pkg::ST_IDLE;
			bitcnt <= '0;
			shreg <= '0;
			ackph <= 1'b0;
			mack_ok <= 1'b0;
			sda_oe <= 1'b0;
			addr <= `SNI_ADDR_ZERO;
			O_SDA_O <= 1'b0;
		end else begin
			st <= next_st;
			bitcnt <= next_bitcnt;
			shreg <= next_shreg;
			ackph <= next_ackph;
			mack_ok <= next_mack_ok;
			sda_oe <= next_sda_oe;
			addr <= next_addr;
			O_SDA_O <= 1'b0; // Never drives high
		end
	end

	assign O_SDA_OE = sda_oe;

	// Array write lands on the edge that ends the eighth bit
	always_ff @(posedge I_CLK_SYS) begin
		if (mem_we) begin
			mem[addr] <= shreg;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Write stream: FIFO, then toggle handshake onto the link clock

	logic fifo_out_valid;
	logic [`SNI_FIFO_W-1:0] fifo_out_data;
	logic hs_req;
	logic next_hs_req;
	logic [`SNI_FIFO_W-1:0] hs_data;
	logic [`SNI_FIFO_W-1:0] next_hs_data;
	logic ack_s1;
	logic ack_s2;
	logic hs_idle;
	logic link_ack;

	sni_fifo #(.W(`SNI_FIFO_W), .DEPTH(`SNI_FIFO_DEPTH)) u_fifo (
		.i_clk(I_CLK_SYS),
		.i_rst(I_RST),
		.i_in_valid(mem_we),
		.o_in_ready(fifo_in_ready),
		.i_in_data({addr, shreg}),
		.o_out_valid(fifo_out_valid),
		.i_out_ready(hs_idle),
		.o_out_data(fifo_out_data)
	);

	// Sender holds one word until the far side toggles back
	assign hs_idle = (hs_req == ack_s2);

	always_comb begin
		next_hs_req = hs_req;
		next_hs_data = hs_data;
		if (fifo_out_valid && hs_idle) begin
			next_hs_req = ~hs_req;
			next_hs_data = fifo_out_data;
		end
	end

	always_ff @(posedge I_CLK_SYS) begin
		if (I_RST) begin
			hs_req <= 1'b0;
			hs_data <= '0;
			ack_s1 <= 1'b0;
			ack_s2 <= 1'b0;
		end else begin
			hs_req <= next_hs_req;
			hs_data <= next_hs_data;
			ack_s1 <= link_ack;
			ack_s2 <= ack_s1;
		end
	end

	logic next_link_ack;
	logic req_s1;
	logic req_s2;
	logic next_wr_valid;
	logic [`SNI_ADDR_W-1:0] next_wr_addr;
	logic [`SNI_DATA_W-1:0] next_wr_data;

	// hs_data is stable while a request is pending, so it is read directly
	always_comb begin
		next_link_ack = link_ack;
		next_wr_valid = O_WR_VALID;
		next_wr_addr = O_WR_ADDR;
		next_wr_data = O_WR_DATA;
		if (O_WR_VALID) begin
			if (I_WR_READY) begin
				next_wr_valid = 1'b0;
				next_link_ack = ~link_ack;
			end
		end else if (req_s2 != link_ack) begin
			next_wr_valid = 1'b1;
			next_wr_addr = hs_data[`SNI_FIFO_W-1:`SNI_DATA_W];
			next_wr_data = hs_data[`SNI_DATA_W-1:0];
		end
	end

	always_ff @(posedge I_CLK_LINK) begin
		if (I_RST_LINK) begin
			req_s1 <= 1'b0;
			req_s2 <= 1'b0;
			link_ack <= 1'b0;
			O_WR_VALID <= 1'b0;
			O_WR_ADDR <= '0;
			O_WR_DATA <= '0;
		end else begin
			req_s1 <= hs_req;
			req_s2 <= req_s1;
			link_ack <= next_link_ack;
			O_WR_VALID <= next_wr_valid;
			O_WR_ADDR <= next_wr_addr;
			O_WR_DATA <= next_wr_data;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions and covers

	logic wr_try;
	assign wr_try = scl_fall && !ackph && st == sni_pkg::ST_WDATA && bitcnt == `SNI_BITS_PER_BYTE;

	a_sel_mismatch: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(scl_fall && !ackph && st == sni_pkg::ST_DEV && bitcnt == `SNI_BITS_PER_BYTE &&
		 shreg[`SNI_SEL_MSB:`SNI_SEL_LSB] != sel) |=> (st == sni_pkg::ST_IDLE && !sda_oe))
		else $error("select mismatch was answered");
	a_open_drain: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		O_SDA_O == 1'b0)
		else $error("SDA driven high");
	a_sda_timing: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		$changed(sda_oe) |-> $past(evt_sda))
		else $error("SDA changed away from SCL fall");
	a_wp_refuse: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(wr_try && prot_hit) |=> (!ackph && !sda_oe && addr == $past(addr) && st == sni_pkg::ST_IDLE))
		else $error("protected byte accepted");
	a_wp_open: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(wr_try && !wp && fifo_in_ready) |=> (ackph && sda_oe))
		else $error("unprotected byte refused");
	a_commit_ack: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		mem_we |=> (ackph && sda_oe) ##1 (mem[$past(addr, 2)] == $past(shreg, 2)))
		else $error("byte not committed before acknowledge");
	a_addr_wrap: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		(mem_we && addr == `SNI_ADDR_LAST) |=> addr == `SNI_ADDR_ZERO)
		else $error("address did not wrap");
	a_start_abort: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		start_cond |=> (st == sni_pkg::ST_DEV && bitcnt == 4'h0 && !sda_oe))
		else $error("start not taken");
	a_reset_idle: assert property (@(posedge I_CLK_SYS) disable iff (I_RST)
		$fell(I_RST) |-> (st == sni_pkg::ST_IDLE && !O_SDA_OE))
		else $error("not idle after reset");
	a_link_hold: assert property (@(posedge I_CLK_LINK) disable iff (I_RST_LINK)
		(O_WR_VALID && !I_WR_READY) |=> (O_WR_VALID && $stable(O_WR_ADDR) && $stable(O_WR_DATA)))
		else $error("stream word dropped");

	c_write: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) mem_we);
	c_read: cover property (@(posedge I_CLK_SYS) disable iff (I_RST)
		st == sni_pkg::ST_MACK && scl_fall && mack_ok);
	c_protect: cover property (@(posedge I_CLK_SYS) disable iff (I_RST) wr_try && prot_hit);
	c_wrap: cover property (@(posedge I_CLK_SYS) disable iff (I_RST)
		mem_we && addr == `SNI_ADDR_LAST);

endmodule : sni_slave

`default_nettype wire

// ==== bench/sni_master.sv ====
/*
 * Behavioural two-wire bus master that drives the slave under test.
 * Assumes the bench resolves the open-drain data wire and feeds it back on i_sda.
 */
`timescale 1ns/1ps
`default_nettype none

module sni_master #(
	parameter int Q = 25
) (
	input wire logic i_clk,
	input wire logic i_sda,
	output logic o_scl,
	output logic o_sda_low
);
	////////////////////////////////////////////////////////////////////////////
	// Idle bus: clock stands high, data released to the pull-up
	initial begin
		o_scl = 1'b1;
		o_sda_low = 1'b0;
	end

	// Pins move on falling system edges, away from the slave's sampling edge
	task automatic hold(input int n);
		repeat (n) @(negedge i_clk);
	endtask : hold

	// Start or repeated start: data falls while clock is high
	task automatic start();
		hold(3);
		o_sda_low = 1'b0;
		hold(Q);
		o_scl = 1'b1;
		hold(Q);
		o_sda_low = 1'b1;
		hold(Q);
		o_scl = 1'b0;
	endtask : start

	// Stop: data rises while clock is high
	task automatic stop();
		hold(3);
		o_sda_low = 1'b1;
		hold(Q);
		o_scl = 1'b1;
		hold(Q);
		o_sda_low = 1'b0;
		hold(Q);
	endtask : stop

	// One clock pulse; data moves a few cycles after the fall, not with it,
	// so the slave never mistakes a data edge for a start or stop
	task automatic bit_io(input logic b, output logic s);
		hold(3);
		o_sda_low = ~b;
		hold(Q);
		o_scl = 1'b1;
		hold(Q / 2);
		s = i_sda;
		hold(Q - Q / 2);
		o_scl = 1'b0;
	endtask : bit_io

	// Byte out, most significant bit first; returns the slave's acknowledge
	task automatic put(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask : put

	// Byte in, most significant bit first; then acknowledge or refuse
	task automatic get(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(~ack, s);
	endtask : get
endmodule : sni_master

`default_nettype wire

// ==== bench/tb_top.sv ====
/*
 * Self-checking bench of the two-wire slave and its write stream.
 * Assumes the master model in sni_master.sv and a pull-up on the data wire.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp, msg) begin compares++; if ((got) !== (exp)) begin bad_count++; \
	$display("[FAIL] %0t %s", $time, msg); end end

module tb_top;
	localparam logic [3:0] DEV = 4'h5; // Arbitrary device-type value
	localparam int LIMIT = 90000;
	logic clk = 1'b0, clk_link = 1'b0, rst = 1'b1, rst_link = 1'b1;
	logic scl, sda_low, sda_wire, sda_o, sda_oe, wp = 1'b0, ready_want = 1'b1;
	logic wr_valid, wr_ready = 1'b1, prev_oe = 1'b0;
	logic [2:0] sel = 3'h5;
	logic [12:0] wr_addr;
	logic [7:0] wr_data;
	logic [20:0] got_q[$];
	int bad_count = 0, compares = 0, cyc = 0;

	////////////////////////////////////////////////////////////////////////////
	// Clocks: link clock runs at 64 ns with its own phase
	always #2 clk = ~clk;
	initial begin
		#7;
		forever #32 clk_link = ~clk_link;
	end

	// Open-drain wire: any party pulling low wins, else the pull-up
	assign sda_wire = ~(sda_low | (sda_oe & ~sda_o));

	sni_master m (.i_clk(clk), .i_sda(sda_wire), .o_scl(scl), .o_sda_low(sda_low));

	sni_slave #(.P_DEV_TYPE(DEV)) dut (
		.I_CLK_SYS(clk), .I_RST(rst), .I_CLK_LINK(clk_link), .I_RST_LINK(rst_link),
		.I_SCL(scl), .I_SDA(sda_wire), .O_SDA_O(sda_o), .O_SDA_OE(sda_oe), .I_WP(wp),
		.I_DEVICE_SELECT_PINS(sel), .O_WR_VALID(wr_valid), .I_WR_READY(wr_ready),
		.O_WR_ADDR(wr_addr), .O_WR_DATA(wr_data));

	////////////////////////////////////////////////////////////////////////////
	// Consumer: ready moves off the link edge, words taken on it
	always @(negedge clk_link) wr_ready <= ready_want;
	always @(posedge clk_link) begin
		if (!rst_link && wr_valid === 1'b1 && wr_ready === 1'b1) got_q.push_back({wr_addr, wr_data});
	end

	// Slave may move the data line only while the clock is low, and only pull low
	always @(posedge clk) begin
		if (!rst && sda_oe !== prev_oe) `CHK(scl, 1'b0, "data moved while clock high")
		if (!rst && sda_oe === 1'b1) `CHK(sda_o, 1'b0, "data driven high")
		prev_oe <= sda_oe;
	end

	// Hang guard: a stuck handshake ends the run as a failure
	always @(posedge clk) begin
		cyc++;
		if (cyc == LIMIT) begin
			bad_count++;
			$display("[FAIL] %0t timeout", $time);
			conclude();
		end
	end

	task automatic conclude();
		if (bad_count == 0 && compares > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : conclude

	////////////////////////////////////////////////////////////////////////////
	// Write run: device byte, two address bytes, data d0, d0+1 ... for n bytes or until refused
	task automatic write_run(input logic [15:0] a, input logic [7:0] d0, input int n,
			output int acc);
		logic ack;
		m.start();
		m.put({DEV, sel, 1'b0}, ack);
		`CHK(ack, 1'b1, "device byte not acked")
		m.put(a[15:8], ack);
		`CHK(ack, 1'b1, "high address not acked")
		m.put(a[7:0], ack);
		`CHK(ack, 1'b1, "low address not acked")
		acc = 0;
		while (acc < n) begin
			m.put(d0 + 8'(acc), ack);
			if (ack !== 1'b1) break;
			acc++;
		end
		m.stop();
	endtask : write_run

	// Stream must carry exactly n words: consecutive wrapping addresses, data d0+i
	task automatic check_words(input logic [12:0] a0, input logic [7:0] d0, input int n);
		for (int k = 0; k < 4000 && got_q.size() < n; k++) @(negedge clk);
		repeat (200) @(negedge clk);
		`CHK(got_q.size(), n, "stream word count")
		for (int i = 0; i < n && i < got_q.size(); i++) begin
			`CHK(got_q[i], {a0 + 13'(i), d0 + 8'(i)}, "stream word")
		end
		got_q.delete();
	endtask : check_words

	// Selective read: set address, repeated start, n bytes expected d0+i
	task automatic read_check(input logic [12:0] a, input logic [7:0] d0, input int n);
		logic ack;
		logic [7:0] d;
		m.start();
		m.put({DEV, sel, 1'b0}, ack);
		m.put({3'b000, a[12:8]}, ack);
		m.put(a[7:0], ack);
		m.start();
		m.put({DEV, sel, 1'b1}, ack);
		`CHK(ack, 1'b1, "read device byte not acked")
		for (int i = 0; i < n; i++) begin
			m.get(i < n - 1, d);
			`CHK(d, d0 + 8'(i), "read data")
		end
		m.stop();
	endtask : read_check

	////////////////////////////////////////////////////////////////////////////
	// Upper address bits ignored, wrap past the last location, read back at once
	task automatic s_write_wrap();
		int acc;
		write_run(16'hffff, 8'ha0, 3, acc);
		`CHK(acc, 3, "wrap write refused")
		check_words(13'h1fff, 8'ha0, 3);
		read_check(13'h1fff, 8'ha0, 3);
	endtask : s_write_wrap

	// Only the matching select code and device type are acknowledged, for two pin settings
	task automatic s_select();
		logic ack;
		for (int p = 0; p < 2; p++) begin
			sel = (p == 0) ? 3'h2 : 3'h5;
			for (int s = 0; s < 9; s++) begin
				m.start();
				m.put((s < 8) ? {DEV, 3'(s), 1'b0} : {4'h6, sel, 1'b0}, ack);
				`CHK(ack, (s == int'(sel)), "select decode")
				m.stop();
			end
		end
	endtask : s_select

	// Protected quarter refused with the pin high, writable with it low
	task automatic s_protect();
		int acc;
		wp = 1'b1;
		write_run(16'h17ff, 8'h30, 2, acc);
		`CHK(acc, 1, "protected byte acked")
		check_words(13'h17ff, 8'h30, 1);
		wp = 1'b0;
		write_run(16'h1800, 8'h55, 1, acc);
		`CHK(acc, 1, "unprotected write refused")
		check_words(13'h1800, 8'h55, 1);
	endtask : s_protect

	// Stalled consumer fills the stream buffer until writes are refused
	task automatic s_fifo();
		int acc;
		ready_want = 1'b0;
		write_run(16'h0100, 8'h10, 14, acc);
		`CHK(acc >= 8 && acc < 14, 1'b1, "full buffer not refused")
		ready_want = 1'b1;
		check_words(13'h0100, 8'h10, acc);
	endtask : s_fifo

	////////////////////////////////////////////////////////////////////////////
	// Main sequence: both resets asserted together, link reset spans link edges
	initial begin
		repeat (3) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk_link);
		rst_link = 1'b0;
		repeat (20) @(negedge clk);
		`CHK(sda_oe, 1'b0, "line driven after reset")
		`CHK(wr_valid, 1'b0, "stream valid after reset")
		s_write_wrap();
		s_select();
		s_protect();
		s_fifo();
		conclude();
	end
endmodule : tb_top

`default_nettype wire
